// ===== hdl/ebls_pkg.sv
// shared constants and types for the external bus lane strobe block
package ebls_pkg;
	localparam int EBLS_ADDR_W = 22;
	localparam int EBLS_DATA_W = 32;
	localparam int EBLS_LANES = 4;
	localparam int EBLS_AREAS = 8;
	localparam int EBLS_AREA_W = 3;
	// reset values of the pins
	localparam logic [7:0] EBLS_SEL_IDLE = 8'hFF;
	localparam logic [3:0] EBLS_LANE_NONE = 4'h0;
	localparam logic [21:0] EBLS_ADDR_RST = 22'h000000;
	localparam logic [31:0] EBLS_DATA_RST = 32'h00000000;
	// access target
	typedef enum logic [2:0] {
		EBLS_TGT_ROM = 3'h0,
		EBLS_TGT_RAM = 3'h1,
		EBLS_TGT_PERI = 3'h2,
		EBLS_TGT_EXT8 = 3'h3,
		EBLS_TGT_EXT16 = 3'h4,
		EBLS_TGT_EXT32 = 3'h5
	} ebls_target_t;
	// access size
	typedef enum logic [1:0] {
		EBLS_SZ_BYTE = 2'h0,
		EBLS_SZ_WORD = 2'h1,
		EBLS_SZ_LONG = 2'h2
	} ebls_size_t;
	// bus state, gray along idle -> active -> idle
	typedef enum logic [1:0] {
		EBLS_ST_IDLE = 2'b00,
		EBLS_ST_ACTIVE = 2'b01
	} ebls_state_t;
endpackage : ebls_pkg

// ===== hdl/ebls_lane_dec.sv
// byte lane decoder from target, size and low address bits
`timescale 1ns/1ps
module ebls_lane_dec
	import ebls_pkg::*;
(
	input wire ebls_target_t target, // access target
	input wire ebls_size_t size, // access size
	input wire logic [1:0] addr_lo, // low address bits
	output logic [3:0] lanes // active lanes, bit3 = D31..D24
);
	always_comb begin
		lanes = EBLS_LANE_NONE;
		case (target)
			EBLS_TGT_EXT8: begin
				lanes = 4'h1;
			end
			EBLS_TGT_EXT16: begin
				case (size)
					EBLS_SZ_BYTE: lanes = addr_lo[0] ? 4'h1 : 4'h2;
					default: lanes = 4'h3;
				endcase
			end
			EBLS_TGT_EXT32: begin
				case (size)
					EBLS_SZ_BYTE: begin
						case (addr_lo)
							2'h0: lanes = 4'h8;
							2'h1: lanes = 4'h4;
							2'h2: lanes = 4'h2;
							default: lanes = 4'h1;
						endcase
					end
					EBLS_SZ_WORD: lanes = addr_lo[1] ? 4'h3 : 4'hC;
					default: lanes = 4'hF;
				endcase
			end
			default: lanes = EBLS_LANE_NONE;
		endcase
	end
endmodule : ebls_lane_dec

// ===== hdl/ebls_bus.sv
// external bus pin driver: selects, strobes, address and data lanes
`timescale 1ns/1ps
module ebls_bus
	import ebls_pkg::*;
#(
	parameter int ADDR_W = EBLS_ADDR_W,
	parameter int DATA_W = EBLS_DATA_W
) (
	input wire logic ref_clk, // 40 MHz clock
	input wire logic sys_rst, // sync reset, active high
	input wire logic acc_valid, // access in progress this cycle
	input wire ebls_target_t acc_target, // target space
	input wire ebls_size_t acc_size, // access size
	input wire logic acc_write, // 1 write, 0 read
	input wire logic [EBLS_AREA_W-1:0] acc_area, // external area index
	input wire logic [ADDR_W-1:0] acc_addr, // access address
	input wire logic [DATA_W-1:0] acc_wdata, // write data, lane aligned
	output logic [DATA_W-1:0] acc_rdata, // data captured from read lanes
	output logic [ADDR_W-1:0] bus_addr, // address lines
	output logic [EBLS_AREAS-1:0] area_select_n, // area chip selects
	output logic read_strobe_n, // read strobe
	output logic write_strobe_lane3_n, // write strobe D31..D24
	output logic write_strobe_lane2_n, // write strobe D23..D16
	output logic write_strobe_lane1_n, // write strobe D15..D8
	output logic write_strobe_lane0_n, // write strobe D7..D0
	input wire logic [DATA_W-1:0] data_in, // data lines in
	output logic [DATA_W-1:0] data_out, // data lines out
	output logic [DATA_W-1:0] data_oe // per line enable, high drives
);
	ebls_state_t state_q;
	logic [3:0] lanes;
	logic ext_acc;
	logic [3:0] rd_lanes_q;

	function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] l);
		lane_mask = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
	endfunction : lane_mask

	ebls_lane_dec u_dec (
		.target(acc_target),
		.size(acc_size),
		.addr_lo(acc_addr[1:0]),
		.lanes(lanes)
	);

	assign ext_acc = acc_valid && (lanes != EBLS_LANE_NONE);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= EBLS_ST_IDLE;
		end else begin
			state_q <= ext_acc ? EBLS_ST_ACTIVE : EBLS_ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus_addr <= EBLS_ADDR_RST;
		end else if (acc_valid) begin
			bus_addr <= acc_addr;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !ext_acc) begin
			area_select_n <= EBLS_SEL_IDLE;
		end else begin
			area_select_n <= ~(8'h01 << acc_area);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !ext_acc) begin
			read_strobe_n <= 1'b1;
			{write_strobe_lane3_n, write_strobe_lane2_n,
				write_strobe_lane1_n, write_strobe_lane0_n} <= 4'hF;
		end else begin
			read_strobe_n <= acc_write;
			{write_strobe_lane3_n, write_strobe_lane2_n,
				write_strobe_lane1_n, write_strobe_lane0_n} <=
				acc_write ? ~lanes : 4'hF;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !ext_acc || !acc_write) begin
			data_oe <= EBLS_DATA_RST;
			data_out <= EBLS_DATA_RST;
		end else begin
			data_oe <= lane_mask(lanes);
			data_out <= acc_wdata & lane_mask(lanes);
		end
	end

	// read data sampled one cycle after the strobe went low
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_lanes_q <= EBLS_LANE_NONE;
			acc_rdata <= EBLS_DATA_RST;
		end else begin
			rd_lanes_q <= (ext_acc && !acc_write) ? lanes : EBLS_LANE_NONE;
			if (rd_lanes_q != EBLS_LANE_NONE) begin
				acc_rdata <= data_in & lane_mask(rd_lanes_q);
			end
		end
	end

	// internal targets leave selects, strobes and data lines alone; address lines still follow
	a_internal_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_target inside {EBLS_TGT_ROM, EBLS_TGT_RAM, EBLS_TGT_PERI}
		|=> area_select_n == 8'hFF && read_strobe_n && data_oe == '0)
		else $error("internal access disturbed bus pins");
	a_internal_wr_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_target inside {EBLS_TGT_ROM, EBLS_TGT_RAM, EBLS_TGT_PERI}
		|=> write_strobe_lane3_n && write_strobe_lane2_n
		&& write_strobe_lane1_n && write_strobe_lane0_n)
		else $error("internal access pulsed a write strobe");

	// address lines and area selects
	a_addr_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid |=> bus_addr == $past(acc_addr))
		else $error("address lines do not follow access");
	a_addr_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!acc_valid |=> $stable(bus_addr))
		else $error("address lines moved without an access");
	a_one_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ext_acc |=> area_select_n == ~(8'h01 << $past(acc_area)))
		else $error("wrong area select");
	a_select_onehot: assert property (@(posedge ref_clk) disable iff (sys_rst)
		area_select_n == 8'hFF || $onehot(~area_select_n))
		else $error("more than one area select low");
	a_state_track: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == EBLS_ST_ACTIVE) == (area_select_n != 8'hFF))
		else $error("bus state and area selects disagree");

	// read and write strobes
	a_read_strobes: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ext_acc && !acc_write |=> !read_strobe_n && write_strobe_lane0_n
		&& write_strobe_lane1_n && write_strobe_lane2_n && write_strobe_lane3_n)
		else $error("read strobes wrong");
	a_write_no_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ext_acc && acc_write |=> read_strobe_n)
		else $error("read strobe low during write");
	a_read_released: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ext_acc && !acc_write |=> data_oe == '0)
		else $error("data lines driven during read");

	// lane placement in 8 and 16 bit space
	a_ext8_lane: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT8
		|=> data_oe == 32'h000000FF && !write_strobe_lane0_n && write_strobe_lane1_n)
		else $error("8-bit lane wrong");
	a_ext16_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target inside {EBLS_TGT_EXT8, EBLS_TGT_EXT16}
		|=> data_oe[31:16] == '0 && write_strobe_lane3_n && write_strobe_lane2_n)
		else $error("narrow space upper lanes active");
	a_ext16_byte: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT16
		&& acc_size == EBLS_SZ_BYTE && !acc_addr[0]
		|=> !write_strobe_lane1_n && write_strobe_lane0_n)
		else $error("16-bit upper byte lane wrong");
	a_ext16_lower: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT16
		&& acc_size == EBLS_SZ_BYTE && acc_addr[0]
		|=> data_oe == 32'h000000FF && !write_strobe_lane0_n && write_strobe_lane1_n)
		else $error("16-bit lower byte lane wrong");
	a_ext16_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT16
		&& acc_size != EBLS_SZ_BYTE
		|=> data_oe == 32'h0000FFFF && !write_strobe_lane1_n && !write_strobe_lane0_n)
		else $error("16-bit word lanes wrong");

	// lane placement in 32 bit space
	a_ext32_msb: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT32
		&& acc_size == EBLS_SZ_BYTE && acc_addr[1:0] == 2'h0
		|=> data_oe == 32'hFF000000 && !write_strobe_lane3_n)
		else $error("32-bit msb lane wrong");
	a_ext32_byte2: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT32
		&& acc_size == EBLS_SZ_BYTE && acc_addr[1:0] == 2'h1
		|=> data_oe == 32'h00FF0000 && !write_strobe_lane2_n)
		else $error("32-bit second lane wrong");
	a_ext32_byte3: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT32
		&& acc_size == EBLS_SZ_BYTE && acc_addr[1:0] == 2'h2
		|=> data_oe == 32'h0000FF00 && !write_strobe_lane1_n)
		else $error("32-bit third lane wrong");
	a_ext32_lsb: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT32
		&& acc_size == EBLS_SZ_BYTE && acc_addr[1:0] == 2'h3
		|=> data_oe == 32'h000000FF && !write_strobe_lane0_n && write_strobe_lane1_n)
		else $error("32-bit lsb lane wrong");
	a_ext32_hi_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT32
		&& acc_size == EBLS_SZ_WORD && !acc_addr[1]
		|=> data_oe == 32'hFFFF0000 && !write_strobe_lane3_n && !write_strobe_lane2_n
		&& write_strobe_lane1_n && write_strobe_lane0_n)
		else $error("32-bit upper word lanes wrong");
	a_ext32_lo_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT32
		&& acc_size == EBLS_SZ_WORD && acc_addr[1]
		|=> data_oe == 32'h0000FFFF && !write_strobe_lane1_n && !write_strobe_lane0_n
		&& write_strobe_lane3_n && write_strobe_lane2_n)
		else $error("32-bit lower word lanes wrong");
	a_ext32_long: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && acc_write && acc_target == EBLS_TGT_EXT32
		&& acc_size == EBLS_SZ_LONG
		|=> data_oe == 32'hFFFFFFFF && !write_strobe_lane0_n && !write_strobe_lane1_n
		&& !write_strobe_lane2_n && !write_strobe_lane3_n)
		else $error("32-bit longword lanes wrong");
	a_write_data: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ext_acc && acc_write |=> data_out == ($past(acc_wdata) & data_oe))
		else $error("driven lanes do not carry write data");

	// read data capture, one edge after the strobe
	a_rdata_ext8: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && !acc_write && acc_target == EBLS_TGT_EXT8
		|=> ##1 acc_rdata[31:8] == '0)
		else $error("8-bit read took upper lanes");
	a_rdata_ext16: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_valid && !acc_write && acc_target == EBLS_TGT_EXT16
		|=> ##1 acc_rdata[31:16] == '0)
		else $error("16-bit read took upper lanes");
endmodule : ebls_bus

// ===== tb/ebls_ext_dev.sv
// external device model driving the data lines on reads
`timescale 1ns/1ps
module ebls_ext_dev (
	input wire logic ref_clk, // bus clock
	input wire logic [7:0] area_select_n, // area selects
	input wire logic read_strobe_n, // read strobe
	input wire logic [21:0] bus_addr, // address lines
	input wire logic [31:0] data_out, // block drive value
	input wire logic [31:0] data_oe, // block drive enable
	output logic [31:0] data_in // resolved data lines
);
	logic [31:0] last_q = 32'h00000000;
	logic [31:0] dev;
	// released lines show the inverse of the last level
	always_comb dev = (!read_strobe_n && area_select_n != 8'hFF) ? {10'h2A5, bus_addr} : ~last_q;
	always_comb data_in = (data_oe & data_out) | (~data_oe & dev);
	always @(posedge ref_clk) last_q <= data_in;
endmodule : ebls_ext_dev

// ===== tb/test_external_bus_byte_lane_strobes.sv
// bench for the external bus lane strobe block
`timescale 1ns/1ps
module test_external_bus_byte_lane_strobes;
	import ebls_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic acc_valid = 1'b0;
	ebls_target_t acc_target = EBLS_TGT_ROM;
	ebls_size_t acc_size = EBLS_SZ_BYTE;
	logic acc_write = 1'b0;
	logic [2:0] acc_area = 3'h0;
	logic [21:0] acc_addr = 22'h000000;
	logic [31:0] acc_wdata = 32'h00000000;
	logic [31:0] acc_rdata, data_in, data_out, data_oe;
	logic [21:0] bus_addr;
	logic [7:0] area_select_n;
	logic read_strobe_n;
	wire [3:0] ws_n;
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	logic pend = 1'b0;
	logic [31:0] pend_exp = 32'h00000000;
	always #12.5 ref_clk = ~ref_clk;
	ebls_bus i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .acc_valid(acc_valid),
		.acc_target(acc_target), .acc_size(acc_size), .acc_write(acc_write),
		.acc_area(acc_area), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_rdata(acc_rdata), .bus_addr(bus_addr), .area_select_n(area_select_n),
		.read_strobe_n(read_strobe_n), .write_strobe_lane3_n(ws_n[3]),
		.write_strobe_lane2_n(ws_n[2]), .write_strobe_lane1_n(ws_n[1]),
		.write_strobe_lane0_n(ws_n[0]), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe));
	ebls_ext_dev i_dev (.ref_clk(ref_clk), .area_select_n(area_select_n),
		.read_strobe_n(read_strobe_n), .bus_addr(bus_addr), .data_out(data_out),
		.data_oe(data_oe), .data_in(data_in));
	task automatic conclude();
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// big-endian lanes, bit3 is the most significant lane
	function automatic logic [3:0] lanes_of(ebls_target_t t, ebls_size_t s, logic [1:0] a);
		case (t)
			EBLS_TGT_EXT32: lanes_of = (s == EBLS_SZ_BYTE) ? 4'h8 >> a :
				(s == EBLS_SZ_WORD) ? (a[1] ? 4'h3 : 4'hC) : 4'hF;
			EBLS_TGT_EXT16: lanes_of = (s == EBLS_SZ_BYTE) ? (a[0] ? 4'h1 : 4'h2) : 4'h3;
			EBLS_TGT_EXT8: lanes_of = 4'h1;
			default: lanes_of = 4'h0;
		endcase
	endfunction : lanes_of
	// one cycle of the bus, pins judged after the taking edge
	task automatic acc(input logic v, input ebls_target_t t, input ebls_size_t s,
		input logic w, input logic [2:0] ar, input logic [21:0] ad);
		logic [3:0] ln;
		logic [31:0] m;
		logic ext;
		logic [31:0] wd;
		ln = v ? lanes_of(t, s, ad[1:0]) : 4'h0;
		m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
		ext = ln != 4'h0;
		wd = {ad[9:0], ad} & m;
		acc_valid = v;
		acc_target = t;
		acc_size = s;
		acc_write = w;
		acc_area = ar;
		acc_addr = ad;
		acc_wdata = wd;
		@(posedge ref_clk);
		#2;
		if (pend) chk(acc_rdata, pend_exp);
		pend = ext && !w;
		pend_exp = {10'h2A5, ad} & m;
		chk({24'h0, area_select_n}, {24'h0, ext ? ~(8'h01 << ar) : 8'hFF});
		chk({31'h0, read_strobe_n}, {31'h0, !(ext && !w)});
		chk({28'h0, ws_n}, {28'h0, ~((ext && w) ? ln : 4'h0)});
		chk(data_oe, (ext && w) ? m : 32'h0);
		chk(data_out, (ext && w) ? wd : 32'h0);
		chk({10'h0, bus_addr}, {10'h0, ad});
	endtask : acc
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 1000) begin
			num_errors++;
			conclude();
		end
	end
	// every target, size, direction and low address pair, idle gap per size
	task automatic scen_sweep();
		for (int t = 0; t < 6; t++) begin
			for (int s = 0; s < 3; s++) begin
				for (int k = 0; k < 8; k++) begin
					acc(1'b1, ebls_target_t'(t), ebls_size_t'(s), k[0], 3'(t + s + k),
						{20'(t * 37 + s * 511 + k * 9973), k[2:1]});
				end
				acc(1'b0, EBLS_TGT_EXT32, EBLS_SZ_LONG, 1'b1, 3'h1, acc_addr);
			end
		end
	endtask : scen_sweep
	// reads back to back, then a write right behind a read
	task automatic scen_back_to_back();
		acc(1'b1, EBLS_TGT_EXT32, EBLS_SZ_BYTE, 1'b0, 3'h5, 22'h123451);
		acc(1'b1, EBLS_TGT_EXT16, EBLS_SZ_WORD, 1'b0, 3'h2, 22'h0F0F02);
		acc(1'b1, EBLS_TGT_EXT8, EBLS_SZ_LONG, 1'b0, 3'h7, 22'h3FFFFF);
		acc(1'b1, EBLS_TGT_EXT32, EBLS_SZ_WORD, 1'b1, 3'h0, 22'h2AAAAA);
		acc(1'b0, EBLS_TGT_ROM, EBLS_SZ_BYTE, 1'b0, 3'h0, 22'h2AAAAA);
	endtask : scen_back_to_back
	// reset over a standing read, first request at the first edge after release
	task automatic scen_mid_reset();
		acc(1'b1, EBLS_TGT_EXT32, EBLS_SZ_LONG, 1'b0, 3'h3, 22'h155554);
		sys_rst = 1'b1;
		@(posedge ref_clk);
		#2;
		pend = 1'b0;
		chk(acc_rdata, EBLS_DATA_RST);
		chk({24'h0, area_select_n}, {24'h0, EBLS_SEL_IDLE});
		chk({31'h0, read_strobe_n}, 32'h00000001);
		chk({28'h0, ws_n}, 32'h0000000F);
		chk(data_oe, EBLS_DATA_RST);
		chk({10'h0, bus_addr}, {10'h0, EBLS_ADDR_RST});
		sys_rst = 1'b0;
		acc(1'b1, EBLS_TGT_EXT16, EBLS_SZ_BYTE, 1'b1, 3'h4, 22'h000000);
		acc(1'b0, EBLS_TGT_RAM, EBLS_SZ_BYTE, 1'b0, 3'h0, 22'h000000);
	endtask : scen_mid_reset
	initial begin
		repeat (12) @(posedge ref_clk);
		#2;
		sys_rst = 1'b0;
		acc(1'b0, EBLS_TGT_ROM, EBLS_SZ_BYTE, 1'b0, 3'h0, 22'h000000);
		scen_sweep();
		scen_back_to_back();
		scen_mid_reset();
		conclude();
	end
endmodule : test_external_bus_byte_lane_strobes
